/* File: hdl/chgi_top.sv */
// Charger serial target, event flags, interrupt and measurement handshake
// Functional notes
// - Interrupt active only while enabled flag set
// - Enables cover faults, attach, conversion complete
// - Enables gate interrupt only, never alarm
// - Standalone build: open-drain low attach indicator
// - Host sets request; device clears when done
// - Result arrival sets conversion-complete flag
// - Results held until next request
// - Results are 8-bit codes, voltage full scale
// - Current and temperature codes linearly scaled
// - Eight data bits plus ack clock, framed
// - Clock input only; data open-drain low
// - One bit per clock, stable while high
// - Detect start and stop while clock high
// - Stop anywhere except start's high pulse
// - Never hold clock line low
// - No ack for general call address
// - Address 0x30 plus strap, then direction
// - Pull data low through ninth clock high
// - Write frame: address, register, data, stop
// - Read frame: address, register, restart, data
// - Alarm asserted while any fault persists
// - Reading flags clears them; live faults reassert
// - Low address bits from strap at enable
`timescale 1ns/1ps

module chgi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage writes
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // chgi_fifo

module chgi_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] strap_pin_one_i,
  input wire logic standalone_i,
  input wire logic attached_i,
  input wire logic [chgi_pkg::NUM_FAULTS-1:0] fault_i,
  output logic int_oe_o,
  output logic alarm_oe_o,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [7:0] bus_voltage_sample_i,
  input wire logic [7:0] load_current_sample_i,
  input wire logic [7:0] die_temp_sample_i
);
  // Synchronisers: first stage read only by second
  logic [1:0] scl_sync_reg, sda_sync_reg, strap_s1_reg, strap_s2_reg;
  logic standalone_s1_reg, standalone_s2_reg, attach_s1_reg, attach_s2_reg;
  logic [chgi_pkg::NUM_FAULTS-1:0] fault_s1_reg, fault_s2_reg;
  logic scl_prev_reg, sda_prev_reg, attach_prev_reg;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
      standalone_s1_reg <= 1'b0;
      standalone_s2_reg <= 1'b0;
      attach_s1_reg <= 1'b0;
      attach_s2_reg <= 1'b0;
      attach_prev_reg <= 1'b0;
      fault_s1_reg <= '0;
      fault_s2_reg <= '0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
      strap_s1_reg <= strap_pin_one_i;
      strap_s2_reg <= strap_s1_reg;
      standalone_s1_reg <= standalone_i;
      standalone_s2_reg <= standalone_s1_reg;
      attach_s1_reg <= attached_i;
      attach_s2_reg <= attach_s1_reg;
      attach_prev_reg <= attach_s2_reg;
      fault_s1_reg <= fault_i;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // Strap caught once the synchroniser has settled after reset
  logic [1:0] settle_reg;
  logic strap_taken_reg, standalone_reg;
  logic [6:0] own_addr_reg;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      settle_reg <= '0;
      strap_taken_reg <= 1'b0;
      standalone_reg <= 1'b0;
      own_addr_reg <= chgi_pkg::ADDR_BASE;
    end else if (!strap_taken_reg) begin
      if (settle_reg == chgi_pkg::STRAP_SETTLE) begin
        strap_taken_reg <= 1'b1;
        standalone_reg <= standalone_s2_reg;
        own_addr_reg <= chgi_pkg::ADDR_BASE + {5'h00, strap_s2_reg};
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Register file state
  logic [chgi_pkg::NUM_FLAGS-1:0] flags_reg, masks_reg, ev_set, ev_live;
  logic [7:0] cfg_reg, volt_reg, curr_reg, temp_reg;
  logic adc_req_reg, adc_busy_reg;
  logic [chgi_pkg::NUM_FLAG_REGS-1:0] rd_clr_reg;
  logic [7:0] ptr_reg, rd_data;

  // Read mux; registers are eight bits wide
  always_comb begin
    case (ptr_reg)
      chgi_pkg::REG_FLAG0: rd_data = flags_reg[7:0];
      chgi_pkg::REG_FLAG1: rd_data = flags_reg[15:8];
      chgi_pkg::REG_FLAG2: rd_data = flags_reg[23:16];
      chgi_pkg::REG_MASK0: rd_data = masks_reg[7:0];
      chgi_pkg::REG_MASK1: rd_data = masks_reg[15:8];
      chgi_pkg::REG_MASK2: rd_data = masks_reg[23:16];
      chgi_pkg::REG_CFG: rd_data = cfg_reg;
      chgi_pkg::REG_ADC_REQ: rd_data = {7'h00, adc_req_reg};
      chgi_pkg::REG_VOLT: rd_data = volt_reg;
      chgi_pkg::REG_CURR: rd_data = curr_reg;
      chgi_pkg::REG_TEMP: rd_data = temp_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial target state
  chgi_pkg::chgi_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg;
  logic rw_reg, start_hi_reg, sda_oe_reg, push_reg;
  logic [15:0] push_data_reg;
  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic addr_hit;
  assign addr_hit = (shift_reg[7:1] == own_addr_reg) &&
                    (shift_reg[7:1] != chgi_pkg::GEN_CALL_ADDR);

  // Bus state machine; clock line is never driven, no stretching
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= chgi_pkg::ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      rw_reg <= 1'b0;
      start_hi_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ptr_reg <= '0;
      push_reg <= 1'b0;
      push_data_reg <= '0;
      rd_clr_reg <= '0;
    end else begin
      push_reg <= 1'b0;
      rd_clr_reg <= '0;
      if (scl_fall) begin
        start_hi_reg <= 1'b0;
      end
      if (standalone_reg) begin
        state_reg <= chgi_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        // Start or repeated start restarts address phase
        state_reg <= chgi_pkg::ST_ADDR;
        bit_cnt_reg <= '0;
        sda_oe_reg <= 1'b0;
        start_hi_reg <= 1'b1;
      end else if (stop_det && !start_hi_reg) begin
        // Stop honoured at any bit except in start's own high pulse
        state_reg <= chgi_pkg::ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (state_reg != chgi_pkg::ST_IDLE && state_reg != chgi_pkg::ST_IGNORE) begin
        if (scl_rise && bit_cnt_reg < chgi_pkg::BIT_LAST) begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_fall && bit_cnt_reg == chgi_pkg::BIT_LAST) begin
          // Byte complete: ack slot held until next clock fall
          bit_cnt_reg <= chgi_pkg::BIT_ACK;
          sda_oe_reg <= 1'b0;
          case (state_reg)
            chgi_pkg::ST_ADDR: begin
              if (addr_hit) begin
                sda_oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                if (shift_reg[0] == chgi_pkg::RW_READ) begin
                  tx_reg <= rd_data;
                  for (int r = 0; r < chgi_pkg::NUM_FLAG_REGS; r++) begin
                    rd_clr_reg[r] <= (ptr_reg == chgi_pkg::REG_FLAG0 + 8'(r));
                  end
                end
              end else begin
                state_reg <= chgi_pkg::ST_IGNORE;
              end
            end
            chgi_pkg::ST_REG: begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
            end
            chgi_pkg::ST_DATA_W: begin
              // Full queue refuses the byte with no ack
              if (fifo_in_ready) begin
                push_reg <= 1'b1;
                push_data_reg <= {ptr_reg, shift_reg};
                sda_oe_reg <= 1'b1;
              end
            end
            default: sda_oe_reg <= 1'b0; // Master acks read byte
          endcase
        end else if (scl_fall && bit_cnt_reg == chgi_pkg::BIT_ACK) begin
          bit_cnt_reg <= '0;
          sda_oe_reg <= 1'b0;
          case (state_reg)
            chgi_pkg::ST_ADDR: begin
              if (rw_reg == chgi_pkg::RW_READ) begin
                state_reg <= chgi_pkg::ST_DATA_R;
                sda_oe_reg <= !tx_reg[7];
              end else begin
                state_reg <= chgi_pkg::ST_REG;
              end
            end
            chgi_pkg::ST_REG: state_reg <= chgi_pkg::ST_DATA_W;
            default: state_reg <= chgi_pkg::ST_IGNORE; // One data byte per frame
          endcase
        end else if (scl_fall && state_reg == chgi_pkg::ST_DATA_R &&
                     bit_cnt_reg != '0) begin
          // Shift out next bit; only ever pull low
          sda_oe_reg <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
        end
      end
    end
  end

  // Write queue between serial side and register file
  logic drain_ready;
  assign drain_ready = (rd_clr_reg == '0); // Stall while a read-clear lands
  chgi_fifo #(
    .WIDTH(chgi_pkg::FIFO_WIDTH),
    .DEPTH(chgi_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain_ready),
    .out_data_o(fifo_out_data)
  );

  logic wr_en;
  logic [7:0] wr_ptr, wr_val;
  assign wr_en = fifo_out_valid && drain_ready;
  assign wr_ptr = fifo_out_data[15:8];
  assign wr_val = fifo_out_data[7:0];

  // Enable and configuration registers written from queue
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      masks_reg <= {chgi_pkg::MASK_RST, chgi_pkg::MASK_RST, chgi_pkg::MASK_RST};
      cfg_reg <= chgi_pkg::CFG_RST;
    end else if (wr_en) begin
      case (wr_ptr)
        chgi_pkg::REG_MASK0: masks_reg[7:0] <= wr_val;
        chgi_pkg::REG_MASK1: masks_reg[15:8] <= wr_val;
        chgi_pkg::REG_MASK2: masks_reg[23:16] <= wr_val;
        chgi_pkg::REG_CFG: cfg_reg <= wr_val;
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // Measurement handshake; request bit self-clears on completion
  logic adc_start_reg, adc_done_evt;
  assign adc_done_evt = adc_done_i && adc_busy_reg;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      adc_req_reg <= 1'b0;
      adc_busy_reg <= 1'b0;
      adc_start_reg <= 1'b0;
      volt_reg <= chgi_pkg::SAMPLE_RST;
      curr_reg <= chgi_pkg::SAMPLE_RST;
      temp_reg <= chgi_pkg::SAMPLE_RST;
    end else begin
      adc_start_reg <= 1'b0;
      if (adc_done_evt) begin
        adc_req_reg <= 1'b0;
        adc_busy_reg <= 1'b0;
        volt_reg <= bus_voltage_sample_i;
        curr_reg <= load_current_sample_i;
        temp_reg <= die_temp_sample_i;
      end else if (wr_en && wr_ptr == chgi_pkg::REG_ADC_REQ &&
                   wr_val[chgi_pkg::ADC_REQ_BIT]) begin
        adc_req_reg <= 1'b1;
      end else if (adc_req_reg && !adc_busy_reg) begin
        adc_busy_reg <= 1'b1;
        adc_start_reg <= 1'b1;
      end
    end
  end

  // Event sources: conversion done, attach rise, live faults
  assign ev_set = {fault_s2_reg, {chgi_pkg::FLAG0_SPARE{1'b0}},
                   attach_s2_reg && !attach_prev_reg, adc_done_evt};
  assign ev_live = {fault_s2_reg, 8'h00};

  // Flags: set beats clear so no event is lost
  generate
    for (genvar i = 0; i < chgi_pkg::NUM_FLAGS; i++) begin : g_flag
      logic clr;
      assign clr = rd_clr_reg[i / 8] ||
                   (cfg_reg[chgi_pkg::CFG_SELF_CLR_BIT] && i >= 8 && !ev_live[i]);
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          flags_reg[i] <= 1'b0;
        end else begin
          flags_reg[i] <= ev_set[i] || (flags_reg[i] && !clr);
        end
      end
    end
  endgenerate

  // Pin drivers; interrupt gated by enables except in standalone build (attach input), alarm never
  logic int_oe_reg, alarm_oe_reg;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      int_oe_reg <= 1'b0;
      alarm_oe_reg <= 1'b0;
    end else begin
      int_oe_reg <= standalone_reg ? attach_s2_reg
                                   : |(flags_reg & masks_reg);
      alarm_oe_reg <= |fault_s2_reg;
    end
  end

  // Data pin output level is always low: open drain
  logic sda_lvl_reg;
  always_ff @(posedge clk_i) begin
    sda_lvl_reg <= 1'b0;
  end

  assign sda_o = sda_lvl_reg;
  assign sda_oe_o = sda_oe_reg;
  assign int_oe_o = int_oe_reg;
  assign alarm_oe_o = alarm_oe_reg;
  assign adc_start_o = adc_start_reg;
endmodule // chgi_top

/* File: inc/chgi_pkg.sv */
// Shared constants and types for the charger serial diagnostic block
package chgi_pkg;
  // Target address: base plus two strap bits
  localparam logic [6:0] ADDR_BASE = 7'h30;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic RW_READ = 1'b1;

  // Register offsets
  localparam logic [7:0] REG_FLAG0 = 8'h00;
  localparam logic [7:0] REG_FLAG1 = 8'h01;
  localparam logic [7:0] REG_FLAG2 = 8'h02;
  localparam logic [7:0] REG_MASK0 = 8'h03;
  localparam logic [7:0] REG_MASK1 = 8'h04;
  localparam logic [7:0] REG_MASK2 = 8'h05;
  localparam logic [7:0] REG_CFG = 8'h06;
  localparam logic [7:0] REG_ADC_REQ = 8'h07;
  localparam logic [7:0] REG_VOLT = 8'h08;
  localparam logic [7:0] REG_CURR = 8'h09;
  localparam logic [7:0] REG_TEMP = 8'h0a;

  // Field layout
  localparam int FLAG_ADC_DONE = 0;
  localparam int FLAG_ATTACH = 1;
  localparam int FLAG0_SPARE = 6;
  localparam int NUM_FAULTS = 16;
  localparam int NUM_FLAG_REGS = 3;
  localparam int NUM_FLAGS = 24;
  localparam int CFG_SELF_CLR_BIT = 0;
  localparam int ADC_REQ_BIT = 0;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] SAMPLE_RST = 8'h00;

  // Serial framing counts
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Write queue
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_REG    = 3'b010,
    ST_DATA_W = 3'b011,
    ST_DATA_R = 3'b100,
    ST_IGNORE = 3'b101
  } chgi_state_t;
endpackage

/* File: test/chgi_assertions.sv */
// Port-level checks for the charger serial diagnostic block
`timescale 1ns/1ps
module chgi_assertions (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [1:0] strap_pin_one_i,
  input wire logic standalone_i,
  input wire logic attached_i,
  input wire logic [chgi_pkg::NUM_FAULTS-1:0] fault_i,
  input wire logic int_oe_o,
  input wire logic alarm_oe_o,
  input wire logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [7:0] bus_voltage_sample_i,
  input wire logic [7:0] load_current_sample_i,
  input wire logic [7:0] die_temp_sample_i
);
  logic [1:0] up_reg; // Cycles since reset release, saturating
  logic busy_reg; // Conversion outstanding

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Age since reset, so the first edges can be judged on their own
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end

  // Converter busy from start pulse to done
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_reg <= 1'b0;
    end else if (adc_start_o) begin
      busy_reg <= 1'b1;
    end else if (adc_done_i) begin
      busy_reg <= 1'b0;
    end
  end

  a_data_low_only: assert property (sda_o == 1'b0)
    else $error("data pin output level not low");
  a_data_stable_high: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while bus clock high");
  a_alarm_on: assert property ((fault_i != '0) [*5] |=> alarm_oe_o)
    else $error("alarm missing during live fault");
  a_alarm_off: assert property ((fault_i == '0) [*5] |=> !alarm_oe_o)
    else $error("alarm without fault");
  a_attach_on: assert property ((standalone_i && attached_i) [*8] |=> int_oe_o)
    else $error("attach indicator missing");
  a_attach_off: assert property ((standalone_i && !attached_i) [*8] |=> !int_oe_o)
    else $error("attach indicator without attach");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start pulse longer than one cycle");
  a_start_once: assert property (adc_start_o |-> !busy_reg)
    else $error("second start while converting");
  a_quiet_start: assert property (up_reg < 2'h2 |->
    !(int_oe_o || sda_oe_o || adc_start_o || alarm_oe_o))
    else $error("output active right after reset");
endmodule // chgi_assertions

bind chgi_top chgi_assertions chgi_assertions_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .strap_pin_one_i(strap_pin_one_i), .standalone_i(standalone_i), .attached_i(attached_i),
  .fault_i(fault_i), .int_oe_o(int_oe_o), .alarm_oe_o(alarm_oe_o), .adc_start_o(adc_start_o),
  .adc_done_i(adc_done_i), .bus_voltage_sample_i(bus_voltage_sample_i),
  .load_current_sample_i(load_current_sample_i), .die_temp_sample_i(die_temp_sample_i));

/* File: test/chgi_master.sv */
// Behavioural two-wire bus master facing the block's serial port
`timescale 1ns/1ps
module chgi_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  logic nak; // Any byte of the last frame, other than a read data byte, left unacknowledged

  // Bus idles released, clock standing high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nak = 1'b0;
  end

  // One bit per 64 ns clock; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    #16 scl_o = 1'b1;
    #16 r = sda_i;
    #16 scl_o = 1'b0;
    #16;
  endtask

  // Start or repeated start: data falls with clock high
  task automatic start();
    sda_low_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_low_o = 1'b1;
    #16 scl_o = 1'b0;
    #16;
  endtask

  // Stop: data rises with clock high, clock then stands still
  task automatic stop();
    sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 sda_low_o = 1'b0;
    #32;
  endtask

  // Eight bits MSB first plus the acknowledge clock
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, input logic chk);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (chk) nak = nak | a;
  endtask

  task automatic wr(input logic [6:0] a7, input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    nak = 1'b0;
    start();
    xfer({a7, 1'b0}, q, 1'b1);
    xfer(r, q, 1'b1);
    xfer(d, q, 1'b1);
    stop();
  endtask

  // Read data byte is refused by the master so the target lets go
  task automatic rd(input logic [6:0] a7, input logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    nak = 1'b0;
    start();
    xfer({a7, 1'b0}, q, 1'b1);
    xfer(r, q, 1'b1);
    start();
    xfer({a7, 1'b1}, q, 1'b1);
    xfer(8'hff, d, 1'b0);
    stop();
  endtask
endmodule // chgi_master

/* File: test/testbench.sv */
// Self-checking bench for the charger serial diagnostic block
`timescale 1ns/1ps
module testbench;
  logic clk_i, resetn_i, standalone_i, attached_i, adc_done_i;
  logic [1:0] strap_pin_one_i;
  logic [chgi_pkg::NUM_FAULTS-1:0] fault_i;
  logic [7:0] volt_i, curr_i, temp_i, q;
  logic sda_o, sda_oe_o, int_oe_o, alarm_oe_o, adc_start_o, scl, sda_low, sda_w;
  logic [6:0] addr;
  logic [31:0] seed = 32'hb91b62a9;
  int fail_count = 0;
  int cmp_count = 0;
  int starts = 0;
  int k;
  int mreg [12];

  // Open-drain data wire with pull-up
  assign sda_w = (sda_oe_o ? sda_o : 1'b1) & !sda_low;

  chgi_top chgi_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_pin_one_i(strap_pin_one_i),
    .standalone_i(standalone_i), .attached_i(attached_i), .fault_i(fault_i),
    .int_oe_o(int_oe_o), .alarm_oe_o(alarm_oe_o), .adc_start_o(adc_start_o),
    .adc_done_i(adc_done_i), .bus_voltage_sample_i(volt_i),
    .load_current_sample_i(curr_i), .die_temp_sample_i(temp_i));
  chgi_master chgi_master_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = !clk_i;
  end

  // Count converter start pulses
  always @(posedge clk_i) if (adc_start_o === 1'b1) starts++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Odd half-step offset keeps the master's 16 ns steps off the rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1.5;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    chgi_master_i.wr(addr, r, d);
    check("write ack", 8'h00, 8'(chgi_master_i.nak));
    if (r inside {[3:6]}) mreg[r] = d;
    tick(4);
  endtask

  // Flag registers clear in the model once read
  task automatic rd(input logic [7:0] r);
    chgi_master_i.rd(addr, r, q);
    check("read ack", 8'h00, 8'(chgi_master_i.nak));
    check("register", mreg[r][7:0], q);
    if (r < 3) mreg[r] = 0;
    tick(4);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    resetn_i = 1'b0;
    standalone_i = 1'b0;
    attached_i = 1'b0;
    adc_done_i = 1'b0;
    fault_i = '0;
    volt_i = 8'h00;
    curr_i = 8'h00;
    temp_i = 8'h00;
    seed = lfsr(seed);
    strap_pin_one_i = seed[1:0];
    addr = chgi_pkg::ADDR_BASE | 7'(seed[1:0]);
    mreg = '{default: 0};
    tick(4);
    resetn_i = 1'b1;
    tick(12);
    // Reset values; unmapped place reads zero and ignores writes
    for (int r = 0; r < 12; r++) rd(8'(r));
    wr(8'h0b, 8'h5a);
    rd(8'h0b);
    $display("test reset_values done");
    // Random enable patterns written and read back
    for (int r = 3; r < 6; r++) begin
      seed = lfsr(seed);
      wr(8'(r), seed[7:0]);
      rd(8'(r));
    end
    $display("test enables done");
    // Other target address and general call are left unanswered
    chgi_master_i.wr(addr ^ 7'h01, 8'h03, 8'hff);
    check("other ack", 8'h01, 8'(chgi_master_i.nak));
    chgi_master_i.wr(chgi_pkg::GEN_CALL_ADDR, 8'h03, 8'hff);
    check("gencall ack", 8'h01, 8'(chgi_master_i.nak));
    rd(8'h03);
    $display("test refused done");
    // Conversion handshake, completion flag and held results
    wr(8'h03, 8'h01);
    starts = 0;
    wr(8'h07, 8'h01);
    check("start pulses", 8'h01, 8'(starts));
    mreg[7] = 1;
    rd(8'h07);
    seed = lfsr(seed);
    volt_i = seed[7:0];
    curr_i = seed[15:8];
    temp_i = seed[23:16];
    mreg[8] = volt_i;
    mreg[9] = curr_i;
    mreg[10] = temp_i;
    adc_done_i = 1'b1;
    tick(1);
    adc_done_i = 1'b0;
    tick(3);
    check("int after done", 8'h01, 8'(int_oe_o));
    volt_i = ~volt_i;
    curr_i = ~curr_i;
    temp_i = ~temp_i;
    mreg[7] = 0;
    mreg[0] = 1;
    for (int r = 7; r < 11; r++) rd(8'(r));
    rd(8'h00);
    check("int released", 8'h00, 8'(int_oe_o));
    attached_i = 1'b1;
    tick(8);
    mreg[0] = 2;
    rd(8'h00);
    $display("test conversion done");
    // Live fault: alarm ignores enables, flag re-sets after a read
    seed = lfsr(seed);
    k = int'(seed[3:0]);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    fault_i[k] = 1'b1;
    tick(8);
    check("alarm on", 8'h01, 8'(alarm_oe_o));
    check("int masked", 8'h00, 8'(int_oe_o));
    wr(8'(4 + k / 8), 8'h01 << (k % 8));
    check("int enabled", 8'h01, 8'(int_oe_o));
    mreg[1 + k / 8] = 1 << (k % 8);
    rd(8'(1 + k / 8));
    mreg[1 + k / 8] = 1 << (k % 8);
    check("int live", 8'h01, 8'(int_oe_o));
    fault_i[k] = 1'b0;
    tick(8);
    check("alarm off", 8'h00, 8'(alarm_oe_o));
    rd(8'(1 + k / 8));
    rd(8'(1 + k / 8));
    check("int cleared", 8'h00, 8'(int_oe_o));
    // Self-clear mode: the fault flag drops as soon as the fault is gone
    wr(8'h06, 8'h01);
    rd(8'h06);
    fault_i[k] = 1'b1;
    tick(8);
    check("int self-clr on", 8'h01, 8'(int_oe_o));
    fault_i[k] = 1'b0;
    tick(8);
    check("int self-clr off", 8'h00, 8'(int_oe_o));
    rd(8'(1 + k / 8));
    $display("test fault done");
    // Standalone build: shared pin follows the attach input
    resetn_i = 1'b0;
    standalone_i = 1'b1;
    attached_i = 1'b0;
    tick(4);
    resetn_i = 1'b1;
    tick(12);
    check("detached pin", 8'h00, 8'(int_oe_o));
    attached_i = 1'b1;
    tick(8);
    check("attached pin", 8'h01, 8'(int_oe_o));
    $display("test standalone done");
    complete_run();
  end
endmodule // testbench
